// [ppct_pkg.sv]
// Shared constants and types for the PSE port configuration and timer block.
// Assumes a single 100 MHz system clock and a synchronous active-low reset.
package ppct_pkg;

  // Register addresses, reached through the serial-bus register port.
  localparam logic [7:0] ADDR_UNPLUG  = 8'h13;
  localparam logic [7:0] ADDR_PROBE   = 8'h14;
  localparam logic [7:0] ADDR_CADENCE = 8'h15;
  localparam logic [7:0] ADDR_TIMING  = 8'h16;
  localparam logic [7:0] ADDR_MISC    = 8'h17;

  // Field positions.
  localparam int DC_UNPLUG_BIT   = 0;
  localparam int AC_UNPLUG_BIT   = 4;
  localparam int PROBE_BIT       = 0;
  localparam int CLASSIFY_BIT    = 4;
  localparam int CADENCE_BIT     = 0;
  localparam int GUARD_BIT       = 6;
  localparam int UNPLUG_SEL_LSB  = 0;
  localparam int FAULT_SEL_LSB   = 2;
  localparam int START_SEL_LSB   = 4;
  localparam int COOLDOWN_LSB    = 6;

  // Writable-bit masks and reset values.
  localparam logic [7:0] UNPLUG_MASK  = 8'h11;
  localparam logic [7:0] PROBE_MASK   = 8'h11;
  localparam logic [7:0] CADENCE_MASK = 8'h01;
  localparam logic [7:0] UNPLUG_RST   = 8'h00;
  localparam logic [7:0] PROBE_AUTO   = 8'hFF;
  localparam logic [7:0] PROBE_OFF    = 8'h00;
  localparam logic [7:0] CADENCE_RST  = 8'h00;
  localparam logic [7:0] TIMING_RST   = 8'h00;
  localparam logic       GUARD_RST    = 1'h1;
  localparam logic [7:0] READ_NONE    = 8'h00;

  // Operating mode codes.
  localparam logic [1:0] MODE_SHUT   = 2'h0;
  localparam logic [1:0] MODE_MANUAL = 2'h1;
  localparam logic [1:0] MODE_SEMI   = 2'h2;
  localparam logic [1:0] MODE_AUTO   = 2'h3;

  // Two-bit scale selector codes.
  localparam logic [1:0] SEL_C0 = 2'h0;
  localparam logic [1:0] SEL_C1 = 2'h1;
  localparam logic [1:0] SEL_C2 = 2'h2;
  localparam logic [1:0] SEL_C3 = 2'h3;

  // Cooldown multiples of the fault time, as shift amounts (16, 32, 64).
  localparam int COOL_SH_C0 = 4;
  localparam int COOL_SH_C1 = 5;
  localparam int COOL_SH_C2 = 6;

  // Nominal times and their cycle counts.
  localparam int          CLK_HZ       = 100_000_000;
  localparam int          CYC_PER_MS   = CLK_HZ / 1000;
  localparam int          T_UNPLUG_MS  = 350;
  localparam int          T_START_MS   = 60;
  localparam int          T_FAULT_MS   = 60;
  localparam int          T_CADENCE_MS = 2200;
  localparam int          TMR_W        = 32;
  localparam logic [31:0] UNPLUG_CYC   = 32'(T_UNPLUG_MS * CYC_PER_MS);
  localparam logic [31:0] START_CYC    = 32'(T_START_MS * CYC_PER_MS);
  localparam logic [31:0] FAULT_CYC    = 32'(T_FAULT_MS * CYC_PER_MS);
  localparam logic [31:0] CADENCE_CYC  = 32'(T_CADENCE_MS * CYC_PER_MS);

  // Timer slots.
  localparam int TMR_UNPLUG  = 0;
  localparam int TMR_START   = 1;
  localparam int TMR_FAULT   = 2;
  localparam int TMR_COOL    = 3;
  localparam int TMR_CADENCE = 4;
  localparam int NTMR        = 5;

  // Edges after reset release before the strap pins are trusted.
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_DETECT, SEQ_CLASSIFY, SEQ_BACKOFF,
    SEQ_WAIT_PWR, SEQ_STARTUP, SEQ_POWERED, SEQ_COOLDOWN
  } ppct_seq_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ppct_reg_req_type;

  typedef struct packed {
    logic ac_sense_strap;
    logic spare_pair_strap;
    logic mps_present;
    logic overcurrent;
    logic current_limit;
  } ppct_pins_type;

  typedef struct packed {
    logic det_done;
    logic det_pass;
    logic cls_done;
    logic pwr_on_req;
    logic pwr_off_req;
  } ppct_eng_type;

endpackage : ppct_pkg

// [ppct_pin_sync.sv]
// Two-flop synchroniser for the analog and strap pins of the port.
// Assumes the pins are asynchronous to clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
module ppct_pin_sync (
  input  wire logic                   clk_sys_in,
  input  wire logic                   nrst_in,
  input  wire ppct_pkg::ppct_pins_type pins_in,
  output var  ppct_pkg::ppct_pins_type pins_out
);

  typedef struct packed {
    ppct_pkg::ppct_pins_type meta;
    ppct_pkg::ppct_pins_type sync;
  } ppct_sync_st_type;

  ppct_sync_st_type st_ff;
  ppct_sync_st_type nxt_st;

  // The meta stage feeds only the second stage.
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.meta = pins_in;
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pins_out = st_ff.sync;

endmodule : ppct_pin_sync
`default_nettype wire

// [ppct_timer.sv]
// Saturating elapsed-time counter; restarts from zero whenever run drops.
// Assumes the limit is stable while the counter runs.
`timescale 1ns/1ps
`default_nettype none
module ppct_timer (
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  input  wire logic        run_in,
  input  wire logic [31:0] limit_in,
  output logic             expired_out
);

  typedef struct packed {
    logic [ppct_pkg::TMR_W-1:0] cnt;
  } ppct_tmr_st_type;

  ppct_tmr_st_type st_ff;
  ppct_tmr_st_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (!run_in) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt < limit_in) begin
      nxt_st.cnt = st_ff.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign expired_out = run_in && (st_ff.cnt >= limit_in);

endmodule : ppct_timer
`default_nettype wire

// [pse_port_config_timers.sv]
// Port configuration registers and timer sequencer for one PSE port.
// Assumes the serial-bus engine, mode register and analog engine share clk_sys_in.
// Operation
// - Reset loads AC or DC unplug watch enable from latched ac sense strap.
// - Bit 0 at 13h enables DC unplug watch, read/write.
// - Bit 4 at 13h enables AC unplug watch, read/write.
// - Unplug watch runs only while powered and after power good rises.
// - Reset sets detect/classify enable register to FFh.
// - At 14h bit 0 enables load probe, bit 4 classification.
// - Probe precedes classification; classification alone when probe disabled.
// - Entering auto sets 14h to FFh; semi or manual sets 00h.
// - Manual mode enable bits launch once, cleared after one cycle completes.
// - Reset clears 15h except bit 0, taken from spare-pair strap.
// - Cadence enable waits 2.2s after each failed probe before retrying.
// - Timing register at 16h resets to 00h; fields scale timers.
// - Field [1:0] sets unplug window; power drops when maintenance absent longer.
// - Field [3:2] sets fault time, longest overcurrent in startup or run.
// - Field [5:4] sets startup time, longest current limit during startup.
// - Field [7:6] sets cooldown rate, how long port stays off.
// - After overcurrent shutdown with guard on, refuse power until cooldown ends.
// - Cooldown codes give 16, 32, 64 or 0 times fault time.
// - Unplug scales 1, 1/4, 1/2, 2; startup and fault 1, 1/2, 2, 4.
// - Cooldown guard enable defaults to 1 after reset.
// - Power good sets at end of startup, clears on any fault.
`timescale 1ns/1ps
`default_nettype none
module pse_port_config_timers #(
  parameter logic [31:0] UNPLUG_CYC  = ppct_pkg::UNPLUG_CYC,
  parameter logic [31:0] START_CYC   = ppct_pkg::START_CYC,
  parameter logic [31:0] FAULT_CYC   = ppct_pkg::FAULT_CYC,
  parameter logic [31:0] CADENCE_CYC = ppct_pkg::CADENCE_CYC
) (
  input  wire logic                       clk_sys_in,
  input  wire logic                       nrst_in,
  input  wire ppct_pkg::ppct_reg_req_type reg_req_in,
  output logic [7:0]                      reg_rdata_out,
  output logic                            reg_hit_out,
  input  wire logic [1:0]                 port_mode_in,
  input  wire ppct_pkg::ppct_eng_type     eng_in,
  input  wire ppct_pkg::ppct_pins_type    pins_in,
  output logic                            power_enable_out,
  output logic                            port_power_good_out,
  output logic                            detect_start_out,
  output logic                            classify_start_out,
  output logic                            dc_unplug_watch_out,
  output logic                            ac_unplug_watch_out,
  output logic                            cooldown_lockout_out,
  output logic                            cooldown_guard_enable_out
);

  typedef struct packed {
    ppct_pkg::ppct_seq_type seq;
    logic [7:0]             unplug;
    logic [7:0]             probe;
    logic [7:0]             cadence;
    logic [7:0]             timing;
    logic                   guard;
    logic [1:0]             mode_prev;
    logic [1:0]             strap_cnt;
    logic                   strap_done;
    logic                   pwr;
    logic                   port_power_good;
    logic                   det_go;
    logic                   cls_go;
    logic                   dc_watch;
    logic                   ac_watch;
    logic                   lock;
    logic [7:0]             rdata;
    logic                   hit;
  } ppct_top_st_type;

  localparam ppct_top_st_type ST_RST = '{
    seq:        ppct_pkg::SEQ_IDLE,
    unplug:     ppct_pkg::UNPLUG_RST,
    probe:      ppct_pkg::PROBE_AUTO,
    cadence:    ppct_pkg::CADENCE_RST,
    timing:     ppct_pkg::TIMING_RST,
    guard:      ppct_pkg::GUARD_RST,
    mode_prev:  ppct_pkg::MODE_AUTO,
    strap_cnt:  2'h0,
    strap_done: 1'h0,
    pwr:        1'h0,
    port_power_good:      1'h0,
    det_go:     1'h0,
    cls_go:     1'h0,
    dc_watch:   1'h0,
    ac_watch:   1'h0,
    lock:       1'h0,
    rdata:      ppct_pkg::READ_NONE,
    hit:        1'h0
  };

  ppct_top_st_type         st_ff;
  ppct_top_st_type         nxt_st;
  ppct_pkg::ppct_pins_type pins;
  logic [1:0]              unplug_sel;
  logic [1:0]              fault_sel;
  logic [1:0]              start_sel;
  logic [1:0]              cool_sel;
  logic [31:0]             tmr_lim [ppct_pkg::NTMR];
  logic [ppct_pkg::NTMR-1:0] tmr_run;
  logic [ppct_pkg::NTMR-1:0] tmr_exp;
  logic                    manual;
  logic                    auto_mode;
  logic                    fault;

  ppct_pin_sync u_sync (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .pins_in    (pins_in),
    .pins_out   (pins)
  );

  assign unplug_sel = st_ff.timing[ppct_pkg::UNPLUG_SEL_LSB +: 2];
  assign fault_sel  = st_ff.timing[ppct_pkg::FAULT_SEL_LSB +: 2];
  assign start_sel  = st_ff.timing[ppct_pkg::START_SEL_LSB +: 2];
  assign cool_sel   = st_ff.timing[ppct_pkg::COOLDOWN_LSB +: 2];

  // Scaled limits. Shifts keep the nominal figures exact for every code.
  always_comb begin
    unique case (unplug_sel)
      ppct_pkg::SEL_C0: tmr_lim[ppct_pkg::TMR_UNPLUG] = UNPLUG_CYC;
      ppct_pkg::SEL_C1: tmr_lim[ppct_pkg::TMR_UNPLUG] = UNPLUG_CYC >> 2;
      ppct_pkg::SEL_C2: tmr_lim[ppct_pkg::TMR_UNPLUG] = UNPLUG_CYC >> 1;
      ppct_pkg::SEL_C3: tmr_lim[ppct_pkg::TMR_UNPLUG] = UNPLUG_CYC << 1;
    endcase
    unique case (start_sel)
      ppct_pkg::SEL_C0: tmr_lim[ppct_pkg::TMR_START] = START_CYC;
      ppct_pkg::SEL_C1: tmr_lim[ppct_pkg::TMR_START] = START_CYC >> 1;
      ppct_pkg::SEL_C2: tmr_lim[ppct_pkg::TMR_START] = START_CYC << 1;
      ppct_pkg::SEL_C3: tmr_lim[ppct_pkg::TMR_START] = START_CYC << 2;
    endcase
    unique case (fault_sel)
      ppct_pkg::SEL_C0: tmr_lim[ppct_pkg::TMR_FAULT] = FAULT_CYC;
      ppct_pkg::SEL_C1: tmr_lim[ppct_pkg::TMR_FAULT] = FAULT_CYC >> 1;
      ppct_pkg::SEL_C2: tmr_lim[ppct_pkg::TMR_FAULT] = FAULT_CYC << 1;
      ppct_pkg::SEL_C3: tmr_lim[ppct_pkg::TMR_FAULT] = FAULT_CYC << 2;
    endcase
    // The cooldown is a multiple of the programmed fault time.
    unique case (cool_sel)
      ppct_pkg::SEL_C0: tmr_lim[ppct_pkg::TMR_COOL] = tmr_lim[ppct_pkg::TMR_FAULT] << ppct_pkg::COOL_SH_C0;
      ppct_pkg::SEL_C1: tmr_lim[ppct_pkg::TMR_COOL] = tmr_lim[ppct_pkg::TMR_FAULT] << ppct_pkg::COOL_SH_C1;
      ppct_pkg::SEL_C2: tmr_lim[ppct_pkg::TMR_COOL] = tmr_lim[ppct_pkg::TMR_FAULT] << ppct_pkg::COOL_SH_C2;
      ppct_pkg::SEL_C3: tmr_lim[ppct_pkg::TMR_COOL] = '0;
    endcase
    tmr_lim[ppct_pkg::TMR_CADENCE] = CADENCE_CYC;
  end

  // Each timer counts only while its condition holds, so a gap restarts it.
  always_comb begin
    tmr_run[ppct_pkg::TMR_UNPLUG] = (st_ff.dc_watch || st_ff.ac_watch) && !pins.mps_present;
    tmr_run[ppct_pkg::TMR_START]  = (st_ff.seq == ppct_pkg::SEQ_STARTUP);
    tmr_run[ppct_pkg::TMR_FAULT]  = st_ff.pwr && pins.overcurrent;
    tmr_run[ppct_pkg::TMR_COOL]   = (st_ff.seq == ppct_pkg::SEQ_COOLDOWN);
    tmr_run[ppct_pkg::TMR_CADENCE] = (st_ff.seq == ppct_pkg::SEQ_BACKOFF);
  end

  for (genvar i = 0; i < ppct_pkg::NTMR; i++) begin : g_tmr
    ppct_timer u_tmr (
      .clk_sys_in  (clk_sys_in),
      .nrst_in     (nrst_in),
      .run_in      (tmr_run[i]),
      .limit_in    (tmr_lim[i]),
      .expired_out (tmr_exp[i])
    );
  end

  assign manual    = (port_mode_in == ppct_pkg::MODE_MANUAL);
  assign auto_mode = (port_mode_in == ppct_pkg::MODE_AUTO);

  // Overcurrent beyond the fault time, or current limit beyond startup time.
  assign fault = st_ff.pwr &&
                 (tmr_exp[ppct_pkg::TMR_FAULT] ||
                  (tmr_exp[ppct_pkg::TMR_START] && pins.current_limit));

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.det_go = 1'h0;
    nxt_st.cls_go = 1'h0;

    // Straps are caught once, after the synchroniser has filled.
    if (!st_ff.strap_done) begin
      if (st_ff.strap_cnt == ppct_pkg::STRAP_SETTLE) begin
        nxt_st.strap_done = 1'h1;
        nxt_st.unplug[ppct_pkg::AC_UNPLUG_BIT] = pins.ac_sense_strap;
        nxt_st.unplug[ppct_pkg::DC_UNPLUG_BIT] = !pins.ac_sense_strap;
        nxt_st.cadence[ppct_pkg::CADENCE_BIT]  = pins.spare_pair_strap;
      end else begin
        nxt_st.strap_cnt = st_ff.strap_cnt + 2'h1;
      end
    end

    if (port_mode_in != st_ff.mode_prev) begin
      if (auto_mode) begin
        nxt_st.probe = ppct_pkg::PROBE_AUTO;
      end else if (manual || port_mode_in == ppct_pkg::MODE_SEMI) begin
        nxt_st.probe = ppct_pkg::PROBE_OFF;
      end
    end
    nxt_st.mode_prev = port_mode_in;

    unique case (st_ff.seq)
      ppct_pkg::SEQ_IDLE: begin
        if (port_mode_in != ppct_pkg::MODE_SHUT && port_mode_in == st_ff.mode_prev) begin
          if (st_ff.probe[ppct_pkg::PROBE_BIT]) begin
            nxt_st.det_go = 1'h1;
            nxt_st.seq    = ppct_pkg::SEQ_DETECT;
          end else if (st_ff.probe[ppct_pkg::CLASSIFY_BIT]) begin
            nxt_st.cls_go = 1'h1;
            nxt_st.seq    = ppct_pkg::SEQ_CLASSIFY;
          end else if (!auto_mode && eng_in.pwr_on_req) begin
            nxt_st.pwr = 1'h1;
            nxt_st.seq = ppct_pkg::SEQ_STARTUP;
          end
        end
      end
      ppct_pkg::SEQ_DETECT: begin
        if (eng_in.det_done) begin
          if (manual) begin
            nxt_st.probe[ppct_pkg::PROBE_BIT] = 1'h0;
          end
          if (!eng_in.det_pass) begin
            nxt_st.seq = st_ff.cadence[ppct_pkg::CADENCE_BIT] ?
                         ppct_pkg::SEQ_BACKOFF : ppct_pkg::SEQ_IDLE;
          end else if (st_ff.probe[ppct_pkg::CLASSIFY_BIT]) begin
            nxt_st.cls_go = 1'h1;
            nxt_st.seq    = ppct_pkg::SEQ_CLASSIFY;
          end else if (auto_mode) begin
            nxt_st.pwr = 1'h1;
            nxt_st.seq = ppct_pkg::SEQ_STARTUP;
          end else begin
            nxt_st.seq = ppct_pkg::SEQ_WAIT_PWR;
          end
        end
      end
      ppct_pkg::SEQ_CLASSIFY: begin
        if (eng_in.cls_done) begin
          if (manual) begin
            nxt_st.probe[ppct_pkg::CLASSIFY_BIT] = 1'h0;
          end
          if (auto_mode) begin
            nxt_st.pwr = 1'h1;
            nxt_st.seq = ppct_pkg::SEQ_STARTUP;
          end else begin
            nxt_st.seq = ppct_pkg::SEQ_WAIT_PWR;
          end
        end
      end
      ppct_pkg::SEQ_WAIT_PWR: begin
        if (eng_in.pwr_on_req) begin
          nxt_st.pwr = 1'h1;
          nxt_st.seq = ppct_pkg::SEQ_STARTUP;
        end else if (manual) begin
          nxt_st.seq = ppct_pkg::SEQ_IDLE;
        end
      end
      ppct_pkg::SEQ_STARTUP: begin
        if (tmr_exp[ppct_pkg::TMR_START] && !fault) begin
          nxt_st.port_power_good = 1'h1;
          nxt_st.seq   = ppct_pkg::SEQ_POWERED;
        end
      end
      ppct_pkg::SEQ_POWERED: begin
        if (tmr_exp[ppct_pkg::TMR_UNPLUG] || eng_in.pwr_off_req) begin
          nxt_st.pwr   = 1'h0;
          nxt_st.port_power_good = 1'h0;
          nxt_st.seq   = ppct_pkg::SEQ_IDLE;
        end
      end
      ppct_pkg::SEQ_BACKOFF: begin
        if (tmr_exp[ppct_pkg::TMR_CADENCE]) begin
          nxt_st.seq = ppct_pkg::SEQ_IDLE;
        end
      end
      ppct_pkg::SEQ_COOLDOWN: begin
        // Power requests are ignored here until the cooldown runs out.
        if (tmr_exp[ppct_pkg::TMR_COOL]) begin
          nxt_st.seq = ppct_pkg::SEQ_IDLE;
        end
      end
    endcase

    if (fault) begin
      nxt_st.pwr   = 1'h0;
      nxt_st.port_power_good = 1'h0;
      if (st_ff.guard && cool_sel != ppct_pkg::SEL_C3) begin
        nxt_st.seq = ppct_pkg::SEQ_COOLDOWN;
      end else begin
        nxt_st.seq = ppct_pkg::SEQ_IDLE;
      end
    end

    // Shutdown mode ends all activity, but a running cooldown still completes.
    if (port_mode_in == ppct_pkg::MODE_SHUT && st_ff.seq != ppct_pkg::SEQ_COOLDOWN) begin
      nxt_st.pwr   = 1'h0;
      nxt_st.port_power_good = 1'h0;
      nxt_st.seq   = ppct_pkg::SEQ_IDLE;
    end

    // Writes land after the hardware updates, so a set from software in the
    // same cycle as a self-clear is kept.
    if (reg_req_in.wr) begin
      unique case (reg_req_in.addr)
        ppct_pkg::ADDR_UNPLUG: begin
          nxt_st.unplug = reg_req_in.wdata & ppct_pkg::UNPLUG_MASK;
        end
        ppct_pkg::ADDR_PROBE: begin
          nxt_st.probe = (nxt_st.probe & ~ppct_pkg::PROBE_MASK) |
                         (reg_req_in.wdata & ppct_pkg::PROBE_MASK);
        end
        ppct_pkg::ADDR_CADENCE: begin
          nxt_st.cadence = reg_req_in.wdata & ppct_pkg::CADENCE_MASK;
        end
        ppct_pkg::ADDR_TIMING: begin
          nxt_st.timing = reg_req_in.wdata;
        end
        ppct_pkg::ADDR_MISC: begin
          nxt_st.guard = reg_req_in.wdata[ppct_pkg::GUARD_BIT];
        end
        default: begin
        end
      endcase
    end

    // The misc register is owned elsewhere; only our four answer reads.
    if (reg_req_in.rd) begin
      nxt_st.hit = 1'h1;
      unique case (reg_req_in.addr)
        ppct_pkg::ADDR_UNPLUG:  nxt_st.rdata = st_ff.unplug;
        ppct_pkg::ADDR_PROBE:   nxt_st.rdata = st_ff.probe;
        ppct_pkg::ADDR_CADENCE: nxt_st.rdata = st_ff.cadence;
        ppct_pkg::ADDR_TIMING:  nxt_st.rdata = st_ff.timing;
        default: begin
          nxt_st.rdata = ppct_pkg::READ_NONE;
          nxt_st.hit   = 1'h0;
        end
      endcase
    end

    nxt_st.dc_watch = nxt_st.port_power_good && nxt_st.pwr && nxt_st.unplug[ppct_pkg::DC_UNPLUG_BIT];
    nxt_st.ac_watch = nxt_st.port_power_good && nxt_st.pwr && nxt_st.unplug[ppct_pkg::AC_UNPLUG_BIT];
    nxt_st.lock     = (nxt_st.seq == ppct_pkg::SEQ_COOLDOWN);
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_out             = st_ff.rdata;
  assign reg_hit_out               = st_ff.hit;
  assign power_enable_out          = st_ff.pwr;
  assign port_power_good_out       = st_ff.port_power_good;
  assign detect_start_out          = st_ff.det_go;
  assign classify_start_out        = st_ff.cls_go;
  assign dc_unplug_watch_out       = st_ff.dc_watch;
  assign ac_unplug_watch_out       = st_ff.ac_watch;
  assign cooldown_lockout_out      = st_ff.lock;
  assign cooldown_guard_enable_out = st_ff.guard;

endmodule : pse_port_config_timers
`default_nettype wire

// [ppct_engine_model.sv]
// Behavioural analog engine: answers each start pulse after a fixed delay.
// Assumes start pulses are one cycle wide and never overlap.
`timescale 1ns/1ps
`default_nettype none
module ppct_engine_model (
  input  wire logic             clk_sys_in,
  input  wire logic             detect_start_in,
  input  wire logic             classify_start_in,
  input  wire logic             pass_in,
  output var ppct_pkg::ppct_eng_type eng_out
);
  logic [3:0] dly_ff = 4'h0;
  logic       cls_ff = 1'h0;
  initial eng_out = '0;
  always @(posedge clk_sys_in) begin
    eng_out <= '0;
    if (detect_start_in || classify_start_in) begin
      dly_ff <= 4'h6;
      cls_ff <= classify_start_in;
    end else if (dly_ff != 4'h0) begin
      dly_ff <= dly_ff - 4'h1;
      if (dly_ff == 4'h1) begin
        eng_out.det_done <= ~cls_ff;
        eng_out.det_pass <= ~cls_ff & pass_in;
        eng_out.cls_done <= cls_ff;
      end
    end
  end
endmodule : ppct_engine_model
`default_nettype wire

// [ppct_assertions.sv]
// Port-level checker for the configuration and timer block.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ppct_assertions (
  input wire logic                       clk_sys_in,
  input wire logic                       nrst_in,
  input wire ppct_pkg::ppct_reg_req_type reg_req_in,
  input wire logic [7:0]                 reg_rdata_out,
  input wire logic                       reg_hit_out,
  input wire logic                       power_enable_out,
  input wire logic                       port_power_good_out,
  input wire logic                       detect_start_out,
  input wire logic                       classify_start_out,
  input wire logic                       dc_unplug_watch_out,
  input wire logic                       ac_unplug_watch_out,
  input wire logic                       cooldown_lockout_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  property p_hit; reg_req_in.rd && reg_req_in.addr inside {[8'h13:8'h16]} |=> reg_hit_out; endproperty
  a_hit: assert property (p_hit) else $error("mapped read not answered");
  property p_miss; reg_req_in.rd && reg_req_in.addr == 8'h17 |=> !reg_hit_out && reg_rdata_out == 8'h00; endproperty
  a_miss: assert property (p_miss) else $error("unmapped read answered");
  property p_rsv13; reg_req_in.rd && reg_req_in.addr == 8'h13 |=> (reg_rdata_out & 8'hEE) == 8'h00; endproperty
  a_rsv13: assert property (p_rsv13) else $error("reserved unplug bits set");
  property p_rsv15; reg_req_in.rd && reg_req_in.addr == 8'h15 |=> reg_rdata_out[7:1] == 7'h00; endproperty
  a_rsv15: assert property (p_rsv15) else $error("reserved cadence bits set");
  property p_wr16;
    reg_req_in.wr && reg_req_in.addr == 8'h16 ##2 reg_req_in.rd && !reg_req_in.wr && reg_req_in.addr == 8'h16
      |=> reg_rdata_out == $past(reg_req_in.wdata, 3);
  endproperty
  a_wr16: assert property (p_wr16) else $error("timing readback wrong");
  property p_pg; $rose(port_power_good_out) |-> power_enable_out; endproperty
  a_pg: assert property (p_pg) else $error("power good without power");
  property p_watch; $rose(dc_unplug_watch_out || ac_unplug_watch_out) |-> port_power_good_out; endproperty
  a_watch: assert property (p_watch) else $error("watch before power good");
  property p_order; !(detect_start_out && classify_start_out); endproperty
  a_order: assert property (p_order) else $error("probe and classify together");
  property p_lock; cooldown_lockout_out |-> !power_enable_out; endproperty
  a_lock: assert property (p_lock) else $error("power during cooldown");
endmodule : ppct_assertions
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the port block with an engine model on its far side.
// Assumes shortened timers: unplug 40, start 16, fault 8, cadence 32 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys_in = 1'h0;
  logic nrst_in = 1'h0;
  ppct_pkg::ppct_reg_req_type req = '0;
  ppct_pkg::ppct_pins_type pins = 5'h14;
  ppct_pkg::ppct_eng_type eng;
  logic [1:0] mode = 2'h3;
  logic [7:0] rdata;
  logic pass = 1'h1;
  logic hit, pwr, pg, dst, cst, dcw, acw, lock, guard;
  int err_count = 0, comparisons = 0, n, dcnt = 0, ccnt = 0, d0, c0;
  int fl[5] = '{8, 4, 16, 8, 8};
  int cl[5] = '{128, 128, 1024, 0, 0};
  logic [7:0] tm[5] = '{8'h00, 8'h44, 8'h88, 8'hC0, 8'h00};
  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    dcnt += dst;
    ccnt += cst;
  end
  pse_port_config_timers #(.UNPLUG_CYC(32'h28), .START_CYC(32'h10), .FAULT_CYC(32'h8), .CADENCE_CYC(32'h20)) u_dut (
    .clk_sys_in, .nrst_in, .reg_req_in(req), .reg_rdata_out(rdata), .reg_hit_out(hit), .port_mode_in(mode),
    .eng_in(eng), .pins_in(pins), .power_enable_out(pwr), .port_power_good_out(pg), .detect_start_out(dst),
    .classify_start_out(cst), .dc_unplug_watch_out(dcw), .ac_unplug_watch_out(acw),
    .cooldown_lockout_out(lock), .cooldown_guard_enable_out(guard));
  ppct_engine_model u_eng (.clk_sys_in, .detect_start_in(dst), .classify_start_in(cst), .pass_in(pass),
    .eng_out(eng));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    req <= '{a, d, 1'h1, 1'h0};
    @(posedge clk_sys_in);
    req.wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic eh);
    @(posedge clk_sys_in);
    req <= '{a, 8'h00, 1'h0, 1'h1};
    @(posedge clk_sys_in);
    req.rd <= 1'h0;
    @(negedge clk_sys_in);
    check("rdata", rdata, e);
    check("hit", hit, eh);
  endtask : rd
  // Bounded wait; n holds the edges taken, so timing figures can be judged.
  task automatic wt(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 5000) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    if (n >= 5000) err_count++;
  endtask : wt
  task automatic report_and_stop;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    #100_000;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clk_sys_in);
    nrst_in <= 1'h1;
    repeat (6) @(posedge clk_sys_in);
    rd(8'h13, 8'h10, 1'h1);
    rd(8'h14, 8'hFF, 1'h1);
    rd(8'h15, 8'h00, 1'h1);
    rd(8'h16, 8'h00, 1'h1);
    rd(8'h17, 8'h00, 1'h0);
    wr(8'h13, 8'hFF);
    rd(8'h13, 8'h11, 1'h1);
    wr(8'h15, 8'hFF);
    rd(8'h15, 8'h01, 1'h1);
    wr(8'h13, 8'h10);
    wr(8'h15, 8'h00);
    wt(acw, 1'h1);
    check("pg", pg, 1'h1);
    check("dc_watch", dcw, 1'h0);
    for (int i = 0; i < 5; i++) begin
      wr(8'h16, tm[i]);
      rd(8'h16, tm[i], 1'h1);
      wr(8'h17, i == 4 ? 8'h80 : 8'hC0);
      @(negedge clk_sys_in) check("guard", guard, i != 4);
      wt(pg, 1'h1);
      @(posedge clk_sys_in) pins.overcurrent <= 1'h1;
      wt(pwr, 1'h0);
      check("fault_len", n >= fl[i] && n <= fl[i] + 5, 1'h1);
      check("lock", lock, cl[i] != 0);
      @(posedge clk_sys_in) pins.overcurrent <= 1'h0;
      wt(lock, 1'h0);
      check("cool_len", n + 1 >= cl[i] && n <= cl[i] + 3, 1'h1);
    end
    wr(8'h16, 8'h01);
    wt(acw, 1'h1);
    @(posedge clk_sys_in) pins.mps_present <= 1'h0;
    wt(pwr, 1'h0);
    check("unplug_len", n >= 10 && n <= 15, 1'h1);
    @(posedge clk_sys_in) mode <= 2'h0;
    @(posedge clk_sys_in) mode <= 2'h1;
    rd(8'h14, 8'h00, 1'h1);
    d0 = dcnt;
    c0 = ccnt;
    wr(8'h14, 8'h01);
    repeat (20) @(posedge clk_sys_in);
    check("probe_runs", dcnt - d0, 1);
    rd(8'h14, 8'h00, 1'h1);
    wr(8'h14, 8'h10);
    repeat (20) @(posedge clk_sys_in);
    check("class_runs", ccnt - c0, 1);
    check("no_probe", dcnt - d0, 1);
    @(posedge clk_sys_in) mode <= 2'h2;
    rd(8'h14, 8'h00, 1'h1);
    wr(8'h15, 8'h01);
    pass <= 1'h0;
    @(posedge clk_sys_in) mode <= 2'h3;
    rd(8'h14, 8'hFF, 1'h1);
    wt(dst, 1'h1);
    wt(dst, 1'h0);
    wt(dst, 1'h1);
    check("backoff_len", n > 32 && n < 48, 1'h1);
    report_and_stop();
  end
endmodule : tb_top
bind pse_port_config_timers ppct_assertions u_chk (.clk_sys_in, .nrst_in, .reg_req_in, .reg_rdata_out,
  .reg_hit_out, .power_enable_out, .port_power_good_out, .detect_start_out, .classify_start_out,
  .dc_unplug_watch_out, .ac_unplug_watch_out, .cooldown_lockout_out);
`default_nettype wire
